// [common/laser_status_map.svh]
`ifndef LASER_STATUS_MAP_SVH
`define LASER_STATUS_MAP_SVH

// ============================================================
// Register offsets (word addresses on the plain port)
`define ADDR_CONTROL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_IRQ_STATUS 4'h2
`define ADDR_IRQ_MASK 4'h3
`define ADDR_WIDTH 4

// ============================================================
// Control register fields
`define CTRL_OVER_TEMP_BIT 0
`define CTRL_NO_STRIKE_BIT 1
`define CTRL_RESET_VALUE 8'h00

// ============================================================
// Status / interrupt field positions (same layout for status, irq)
`define ST_LASE_BIT 0
`define ST_FAULT_BIT 1
`define ST_READY_BIT 2
`define ST_SHUTTER_BIT 3
`define ST_INTLK_OPEN_BIT 4
`define ST_INHIBIT_BIT 5
`define IRQ_WIDTH 5
`define IRQ_MASK_RESET 5'h00

// ============================================================
// Timing
`define CLK_FREQ_HZ 40000000
`define INHIBIT_TIME_S 5
`define INHIBIT_CYCLES (`INHIBIT_TIME_S * `CLK_FREQ_HZ)
`define INHIBIT_CNT_WIDTH 28

// Shutter indicator flash half-period for the no-strike display
`define FLASH_TIME_MS 250
`define FLASH_CYCLES (`FLASH_TIME_MS * (`CLK_FREQ_HZ / 1000))
`define FLASH_CNT_WIDTH 24

`endif

// [common/laser_status_pkg.sv]
package laser_status_pkg;

    // Inhibit timer state, one-hot
    typedef enum logic [2:0] {
        INH_DISABLED = 3'b001,
        INH_COUNTING = 3'b010,
        INH_ENABLED = 3'b100
    } inhibit_state_t;

endpackage

// [hdl/inhibit_timer.sv]
`timescale 1ns/10ps
`include "laser_status_map.svh"

module inhibit_timer
    import laser_status_pkg::*;
#(
    parameter logic [`INHIBIT_CNT_WIDTH-1:0] INHIBIT_CYCLES = `INHIBIT_CNT_WIDTH'(`INHIBIT_CYCLES)
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic enable_cond, // Condition that must hold for the whole delay
    output logic done, // Delay elapsed and condition still true
    output logic counting // Delay running
);

    inhibit_state_t state_reg;
    logic [`INHIBIT_CNT_WIDTH-1:0] count_reg;

    // ============================================================
    // Delay state machine; any drop of the condition restarts it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= INH_DISABLED;
        end else if (!enable_cond) begin
            state_reg <= INH_DISABLED;
        end else begin
            unique case (state_reg)
                INH_DISABLED: begin
                    state_reg <= INH_COUNTING;
                end
                INH_COUNTING: begin
                    if (count_reg == INHIBIT_CYCLES - 1'b1) begin
                        state_reg <= INH_ENABLED;
                    end
                end
                INH_ENABLED: begin
                    state_reg <= INH_ENABLED;
                end
                default: begin
                    state_reg <= INH_DISABLED;
                end
            endcase
        end
    end

    // Counter clears whenever not counting, so a restart begins at zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (state_reg == INH_COUNTING && enable_cond) begin
            count_reg <= count_reg + 1'b1;
        end else begin
            count_reg <= '0;
        end
    end

    assign done = (state_reg == INH_ENABLED) && enable_cond;
    assign counting = (state_reg == INH_COUNTING);

endmodule

// [hdl/flash_gen.sv]
`timescale 1ns/10ps
`include "laser_status_map.svh"

module flash_gen #(
    parameter logic [`FLASH_CNT_WIDTH-1:0] HALF_CYCLES = `FLASH_CNT_WIDTH'(`FLASH_CYCLES)
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Asynchronous reset, active high
    output logic blink // Square wave for flashing an indicator
);

    logic [`FLASH_CNT_WIDTH-1:0] count_reg;
    logic blink_reg;

    // ============================================================
    // Free-running divider; indicator display only, no safety role
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
            blink_reg <= 1'b0;
        end else if (count_reg == HALF_CYCLES - 1'b1) begin
            count_reg <= '0;
            blink_reg <= ~blink_reg;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign blink = blink_reg;

endmodule

// [hdl/laser_status_outputs.sv]
// Functional notes
// - Lasing-active output closed while beam emitted, open otherwise.
// - Fault output closed on over-temperature or no-strike; no-strike flashes shutter indicator.
// - Fault output open while temperature normal and no no-strike.
// - Ready output closed while laser enabled; lasing follows modulation command.
// - Lasing inhibited five seconds after ready output first closes.
// - Ready output open while laser disabled.
// - Shutter-open output closed only with interlock and shutter request both asserted.
// - Shutter-open output open while laser disabled.
// - Interlock-open output closed while interlock input circuit open.
// - Interlock-open output open while interlock satisfied.
// - Lasing inhibited five seconds after interlock-open output opens again.
// - Held reset/start request disables laser; release starts five-second countdown, then enable.
// - Interlock loss closes shutter, clears ready and shutter status, ignoring shutter request.
// - Interlock faults unlatched; restore re-enables ready and, after delay, lasing.
// - Internal shutter opens on request only while interlock asserted.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "laser_status_map.svh"

module laser_status_outputs
    import laser_status_pkg::*;
#(
    parameter logic [`INHIBIT_CNT_WIDTH-1:0] INHIBIT_CYCLES = `INHIBIT_CNT_WIDTH'(`INHIBIT_CYCLES),
    parameter logic [`FLASH_CNT_WIDTH-1:0] FLASH_CYCLES = `FLASH_CNT_WIDTH'(`FLASH_CYCLES)
) (
    input wire logic clk_sys, // System clock, 40 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic interlock_in, // Remote interlock present, high = satisfied
    input wire logic shutter_request, // Shutter open request
    input wire logic reset_start_request, // Held high keeps laser disabled
    input wire logic modulation_in, // Pulse-width command
    input wire logic over_temp, // Over-temperature fault level
    input wire logic no_strike, // No-strike fault level
    input wire logic [`ADDR_WIDTH-1:0] reg_addr, // Register word address
    input wire logic [7:0] reg_wdata, // Register write data
    input wire logic reg_write, // Write strobe
    input wire logic reg_read, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    output logic irq, // Level interrupt
    output logic lase_active_out, // Closed (1) while emitting
    output logic fault_out, // Closed (1) on fault
    output logic ready_out, // Closed (1) while enabled
    output logic shutter_open_out, // Closed (1) while shutter open
    output logic interlock_open_out, // Closed (1) while interlock open
    output logic shutter_drive, // Internal shutter actuator
    output logic shutter_indicator, // Shutter lamp, flashes on no-strike
    output logic temperature_indicator // Temperature lamp, high = fault
);

    logic [7:0] ctrl_reg;
    logic [`IRQ_WIDTH-1:0] irq_status_reg;
    logic [`IRQ_WIDTH-1:0] irq_mask_reg;
    logic [`IRQ_WIDTH-1:0] prev_outputs_reg;
    logic [`IRQ_WIDTH-1:0] cur_outputs;
    logic [`IRQ_WIDTH-1:0] irq_status_next;
    logic [7:0] reg_rdata_reg;
    logic lase_reg;
    logic fault_reg;
    logic ready_reg;
    logic shutter_reg;
    logic intlk_open_reg;
    logic temp_ind_reg;
    logic shutter_ind_reg;
    logic fault_any;
    logic ready_cond;
    logic lase_allowed;
    logic inhibit_counting;
    logic blink;
    logic temp_fault;
    logic strike_fault;
    logic shutter_cond;
    logic lase_cond;

    // Write strobe aimed at one register word; shared by every writable register
    function automatic logic write_hit(input logic wr, input logic [`ADDR_WIDTH-1:0] addr,
        input logic [`ADDR_WIDTH-1:0] target);
        return wr && (addr == target);
    endfunction

    // ============================================================
    // Conditions
    // Over-temperature: pin level or the software-forced test bit
    assign temp_fault = over_temp | ctrl_reg[`CTRL_OVER_TEMP_BIT];

    // No-strike: pin level or the software-forced test bit
    assign strike_fault = no_strike | ctrl_reg[`CTRL_NO_STRIKE_BIT];

    // Levels only, so clearing the source clears the output without a reset
    assign fault_any = temp_fault | strike_fault;

    // Enabled only with interlock present and start request released; unlatched
    assign ready_cond = interlock_in & ~reset_start_request;

    // Shutter opens only with interlock present; a held start request counts as disabled
    assign shutter_cond = interlock_in & shutter_request & ~reset_start_request;

    // One timer covers both ready closing and interlock restoring, as both
    // start from ready_cond rising; a drop anywhere restarts the delay
    inhibit_timer #(
        .INHIBIT_CYCLES(INHIBIT_CYCLES)
    ) u_inhibit (
        .clk_sys(clk_sys),
        .rst(rst),
        .enable_cond(ready_cond),
        .done(lase_allowed),
        .counting(inhibit_counting)
    );

    flash_gen #(
        .HALF_CYCLES(FLASH_CYCLES)
    ) u_flash (
        .clk_sys(clk_sys),
        .rst(rst),
        .blink(blink)
    );

    // ============================================================
    // Status outputs, registered for glitch-free relay drive
    // Ready follows the enable condition at once; the inhibit gates emission only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= ready_cond;
        end
    end

    // Interlock-open mirrors the pin inverted and is never latched
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            intlk_open_reg <= 1'b0;
        end else begin
            intlk_open_reg <= ~interlock_in;
        end
    end

    // Status and actuator share one flip-flop so they can never disagree
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shutter_reg <= 1'b0;
        end else begin
            shutter_reg <= shutter_cond;
        end
    end

    // Emission needs delay complete, shutter open, no fault and a command
    assign lase_cond = lase_allowed & shutter_cond & ~fault_any & modulation_in;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lase_reg <= 1'b0;
        end else begin
            lase_reg <= lase_cond;
        end
    end

    // Fault output follows the fault levels
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fault_reg <= 1'b0;
        end else begin
            fault_reg <= fault_any;
        end
    end

    // Temperature lamp lights on the over-temperature level alone
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            temp_ind_reg <= 1'b0;
        end else begin
            temp_ind_reg <= temp_fault;
        end
    end

    // Shutter lamp flashes on no-strike, otherwise shows the shutter state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shutter_ind_reg <= 1'b0;
        end else if (strike_fault) begin
            shutter_ind_reg <= blink;
        end else begin
            shutter_ind_reg <= shutter_cond;
        end
    end

    assign lase_active_out = lase_reg;
    assign fault_out = fault_reg;
    assign ready_out = ready_reg;
    assign shutter_open_out = shutter_reg;
    assign interlock_open_out = intlk_open_reg;
    assign shutter_drive = shutter_reg;
    assign shutter_indicator = shutter_ind_reg;
    assign temperature_indicator = temp_ind_reg;

    // ============================================================
    // Interrupts: any change of one of the five status outputs sets its sticky bit
    assign cur_outputs = {intlk_open_reg, shutter_reg, ready_reg, fault_reg, lase_reg};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prev_outputs_reg <= '0;
        end else begin
            prev_outputs_reg <= cur_outputs;
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_comb begin
        irq_status_next = irq_status_reg;
        if (write_hit(reg_write, reg_addr, `ADDR_IRQ_STATUS)) begin
            irq_status_next = irq_status_next & ~reg_wdata[`IRQ_WIDTH-1:0];
        end
        irq_status_next = irq_status_next | (cur_outputs ^ prev_outputs_reg);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ============================================================
    // Control register: software fault test bits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `CTRL_RESET_VALUE;
        end else if (write_hit(reg_write, reg_addr, `ADDR_CONTROL)) begin
            ctrl_reg <= reg_wdata;
        end
    end

    // Interrupt mask, same layout as the status bits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_mask_reg <= `IRQ_MASK_RESET;
        end else if (write_hit(reg_write, reg_addr, `ADDR_IRQ_MASK)) begin
            irq_mask_reg <= reg_wdata[`IRQ_WIDTH-1:0];
        end
    end

    // Register reads; unmapped addresses read zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                `ADDR_CONTROL: begin
                    reg_rdata_reg <= ctrl_reg;
                end
                `ADDR_STATUS: begin
                    reg_rdata_reg <= {2'b00, inhibit_counting, cur_outputs};
                end
                `ADDR_IRQ_STATUS: begin
                    reg_rdata_reg <= {3'b000, irq_status_reg};
                end
                `ADDR_IRQ_MASK: begin
                    reg_rdata_reg <= {3'b000, irq_mask_reg};
                end
                default: begin
                    reg_rdata_reg <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata = reg_rdata_reg;

endmodule

// [tb/laser_status_sva.sv]
`timescale 1ns/10ps
`include "laser_status_map.svh"

// ====================
// Output checker
module laser_status_sva #(
    parameter logic [`INHIBIT_CNT_WIDTH-1:0] INHIBIT_CYCLES = 28'h14,
    parameter logic [`FLASH_CNT_WIDTH-1:0] FLASH_CYCLES = 24'h4
) (
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic interlock_in, // Input
    input wire logic shutter_request, // Input
    input wire logic reset_start_request, // Input
    input wire logic modulation_in, // Input
    input wire logic over_temp, // Input
    input wire logic no_strike, // Input
    input wire logic lase_active_out, // Output
    input wire logic fault_out, // Output
    input wire logic ready_out, // Output
    input wire logic shutter_open_out, // Output
    input wire logic interlock_open_out, // Output
    input wire logic shutter_drive // Output
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Cycles the enabling condition has held; a drop restarts it, so a short glitch cannot shorten the wait
    logic [`INHIBIT_CNT_WIDTH-1:0] held_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            held_reg <= '0;
        else if (!interlock_in || reset_start_request)
            held_reg <= '0;
        else if (held_reg != '1)
            held_reg <= held_reg + 1'b1;
    end

    // Output relations
    a_lase_has_cause: assert property (
        lase_active_out |-> $past(modulation_in && interlock_in && shutter_request))
        else $error("lasing without command");
    a_lase_after_inhibit: assert property (
        lase_active_out |-> held_reg >= INHIBIT_CYCLES)
        else $error("lasing inside inhibit");
    a_fault_closes: assert property (
        over_temp || no_strike |=> fault_out)
        else $error("fault not shown");
    a_ready_closes: assert property (
        interlock_in && !reset_start_request |=> ready_out)
        else $error("ready not shown");
    a_ready_opens: assert property (
        !interlock_in || reset_start_request |=> !ready_out)
        else $error("ready while disabled");
    a_shutter_closes: assert property (
        interlock_in && shutter_request && !reset_start_request |=> shutter_open_out)
        else $error("shutter not shown");
    a_shutter_opens: assert property (
        !(interlock_in && shutter_request) |=> !shutter_open_out && !shutter_drive)
        else $error("shutter open without both");
    a_intlk_open_shown: assert property (
        !interlock_in |=> interlock_open_out)
        else $error("interlock open not shown");
    a_intlk_ok_shown: assert property (
        interlock_in |=> !interlock_open_out)
        else $error("interlock open while satisfied");

    c_lase: cover property ($rose(lase_active_out));
    c_fault: cover property ($rose(fault_out));
    c_intlk: cover property ($rose(interlock_open_out));
endmodule

bind laser_status_outputs laser_status_sva #(.INHIBIT_CYCLES(INHIBIT_CYCLES), .FLASH_CYCLES(FLASH_CYCLES)) u_sva (
    .clk_sys(clk_sys), .rst(rst), .interlock_in(interlock_in), .shutter_request(shutter_request),
    .reset_start_request(reset_start_request), .modulation_in(modulation_in), .over_temp(over_temp),
    .no_strike(no_strike), .lase_active_out(lase_active_out), .fault_out(fault_out), .ready_out(ready_out),
    .shutter_open_out(shutter_open_out), .interlock_open_out(interlock_open_out), .shutter_drive(shutter_drive)
);

// [tb/plc_model.sv]
`timescale 1ns/10ps

// ====================
// Machine controller driving the user inputs
module plc_model (
    input wire logic clk_sys, // Clock
    input wire logic [3:0] cmd, // Wanted levels: hold, interlock, shutter, pwm
    output logic reset_start_request = 1'b1, // To device; power up holding the laser disabled
    output logic interlock_in = 1'b0, // To device
    output logic shutter_request = 1'b0, // To device
    output logic modulation_in = 1'b0 // To device
);
    // Levels change just after an edge, as a controller output would
    always @(posedge clk_sys) begin
        {reset_start_request, interlock_in, shutter_request, modulation_in} <= cmd;
    end
endmodule

// [tb/laser_status_outputs_bench.sv]
`timescale 1ns/10ps
`include "laser_status_map.svh"

// ====================
// Bench top
module laser_status_outputs_bench
    import laser_status_pkg::*;
;
    logic clk_sys = 1'b0, rst = 1'b1, over_temp = 1'b0, no_strike = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [3:0] cmd = 4'h8, reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, v, pins;
    logic irq, lase_active_out, fault_out, ready_out, shutter_open_out, interlock_open_out;
    logic shutter_drive, shutter_indicator, temperature_indicator;
    logic interlock_in, shutter_request, reset_start_request, modulation_in;
    int errors = 0, comparisons = 0;
    // Pins packed in the status layout so one compare covers all five
    assign pins = {3'h0, interlock_open_out, shutter_open_out, ready_out, fault_out, lase_active_out};

    always #12.5 clk_sys = ~clk_sys;

    plc_model plc (.clk_sys(clk_sys), .cmd(cmd), .reset_start_request(reset_start_request),
        .interlock_in(interlock_in), .shutter_request(shutter_request), .modulation_in(modulation_in));
    laser_status_outputs #(.INHIBIT_CYCLES(28'h14), .FLASH_CYCLES(24'h4)) dut (.clk_sys(clk_sys), .rst(rst),
        .interlock_in(interlock_in), .shutter_request(shutter_request), .reset_start_request(reset_start_request),
        .modulation_in(modulation_in), .over_temp(over_temp), .no_strike(no_strike), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
        .lase_active_out(lase_active_out), .fault_out(fault_out), .ready_out(ready_out),
        .shutter_open_out(shutter_open_out), .interlock_open_out(interlock_open_out),
        .shutter_drive(shutter_drive), .shutter_indicator(shutter_indicator),
        .temperature_indicator(temperature_indicator));

    // ====================
    // Shared tasks
    task test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Partner adds one edge, the outputs one more
    task drive(input logic [3:0] c, input logic ot, input logic ns);
        @(posedge clk_sys);
        cmd <= c;
        over_temp <= ot;
        no_strike <= ns;
        cyc(2);
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // ====================
    // Scenarios
    task t_regs;
        chk(pins, 8'h10);
        rd(`ADDR_CONTROL, v);
        chk(v, `CTRL_RESET_VALUE);
        rd(`ADDR_IRQ_MASK, v);
        chk(v, 8'h00);
        wr(4'hf, 8'hff);
        rd(4'hf, v);
        chk(v, 8'h00);
        rd(`ADDR_STATUS, v);
        chk(v, 8'h10);
    endtask
    task t_enable;
        drive(4'he, 1'b0, 1'b0);
        chk(pins, 8'h00);
        drive(4'h7, 1'b0, 1'b0);
        chk(pins | {shutter_drive, 7'h0}, 8'h8c);
        rd(`ADDR_STATUS, v);
        chk(v, 8'h2c);
        cyc(10);
        drive(4'h3, 1'b0, 1'b0);
        chk(pins | {shutter_drive, 7'h0}, 8'h10);
        drive(4'h7, 1'b0, 1'b0);
        repeat (16) begin
            chk(pins, 8'h0c);
            cyc(1);
        end
        for (int i = 0; i < 10 && lase_active_out !== 1'b1; i++)
            cyc(1);
        chk(pins, 8'h0d);
        rd(`ADDR_STATUS, v);
        chk(v, 8'h0d);
    endtask
    task t_fault;
        drive(4'h7, 1'b1, 1'b0);
        chk(pins | {temperature_indicator, 7'h0}, 8'h8e);
        drive(4'h6, 1'b0, 1'b0);
        chk(pins | {temperature_indicator, 7'h0}, 8'h0c);
        drive(4'h6, 1'b0, 1'b1);
        chk(pins, 8'h0e);
        v = 8'h00;
        repeat (12) begin
            v = v | (shutter_indicator ? 8'h02 : 8'h01);
            cyc(1);
        end
        chk(v, 8'h03);
        drive(4'h6, 1'b0, 1'b0);
        chk(pins, 8'h0c);
        wr(`ADDR_CONTROL, 8'h01);
        cyc(2);
        chk(pins, 8'h0e);
        rd(`ADDR_CONTROL, v);
        chk(v, 8'h01);
        wr(`ADDR_CONTROL, 8'h00);
        cyc(2);
        chk(pins, 8'h0c);
    endtask
    task t_irq;
        wr(`ADDR_IRQ_STATUS, 8'h1f);
        wr(`ADDR_IRQ_MASK, 8'h10);
        rd(`ADDR_IRQ_STATUS, v);
        chk(v, 8'h00);
        chk({7'h0, irq}, 8'h00);
        drive(4'h2, 1'b0, 1'b0);
        // Sticky bit lands one edge after the output it watches
        cyc(1);
        chk({7'h0, irq}, 8'h01);
        rd(`ADDR_IRQ_STATUS, v);
        chk(v, 8'h1c);
        wr(`ADDR_IRQ_MASK, 8'h00);
        cyc(1);
        chk({7'h0, irq}, 8'h00);
        wr(`ADDR_IRQ_STATUS, 8'h1c);
        rd(`ADDR_IRQ_STATUS, v);
        chk(v, 8'h00);
        drive(4'h6, 1'b0, 1'b0);
        chk(pins, 8'h0c);
    endtask

    // Main sequence: reset held for eight cycles first
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        cyc(2);
        t_regs;
        t_enable;
        t_fault;
        t_irq;
        test_done;
    end
    // Watchdog well beyond the roughly 130 cycles the tests need
    initial begin
        #(25 * 5000);
        errors++;
        test_done;
    end
endmodule
